// ==== verilog/pcs_pkg.sv ====
// Package for the program counter, return stack and indirect address decoder.
// Assumes one core clock; the block's constants live here, while pcs_core writes its port widths as literals.
package pcs_pkg;
   localparam int PC_W         = 15;
   localparam int SP_W         = 5;
   localparam int STACK_DEPTH  = 16;
   localparam logic [4:0]  SP_EMPTY     = 5'h1f;
   localparam logic [4:0]  SP_TOP       = 5'h0f;
   localparam logic [14:0] PC_RESET     = 15'h0000;
   localparam logic [15:0] BANKED_LAST  = 16'h1fff;
   localparam logic [15:0] LINEAR_FIRST = 16'h2000;
   localparam logic [15:0] LINEAR_LAST  = 16'h2fef;
   localparam logic [12:0] GPR_BLOCK    = 13'h0050;
   localparam logic [6:0]  GPR_BASE     = 7'h20;
   localparam logic [6:0]  BANK_SPAN    = 7'h00;
   localparam logic [15:0] PORT0_ADDR   = 16'h0000;
   localparam logic [15:0] PORT1_ADDR   = 16'h0001;
   localparam int FLASH_BIT    = 15;
   localparam int CALL_W       = 11;
   localparam logic [1:0] REG_TOS_LOW  = 2'h0;
   localparam logic [1:0] REG_TOS_HIGH = 2'h1;
   localparam logic [1:0] REG_SP       = 2'h2;
   localparam logic [1:0] REG_FLAGS    = 2'h3;

   typedef enum logic [2:0] {
      PCS_OP_NONE, PCS_OP_CALL, PCS_OP_CALL_VIA_WORKING, PCS_OP_IRQ,
      PCS_OP_RET, PCS_OP_BRW, PCS_OP_BRA, PCS_OP_PCL_WR
   } pcs_op_t;

   typedef struct packed {
      logic [1:0] region;
      logic [15:0] addr;
      logic        suppress;
      logic        read_zero;
   } pcs_ind_t;

   localparam logic [1:0] REGION_DATA  = 2'h0;
   localparam logic [1:0] REGION_FLASH = 2'h1;
   localparam logic [1:0] REGION_NONE  = 2'h2;
endpackage : pcs_pkg

// ==== verilog/pcs_core.sv ====
// Program counter, 16-entry return stack and indirect pointer decoder.
// Assumes instruction execution gives one-cycle op strobes and synchronous inputs.
`timescale 1ns/1ns
`default_nettype none

// Functional notes
// RQ1: A write to the low PC byte loads upper bits from the high latch too.
// RQ2: A call takes bits 10:0 from operand, 14:11 from latch bits 6:3.
// RQ3: Call via working loads low byte from W, upper bits from latch.
// RQ4: Branch via working loads PC plus one plus unsigned W.
// RQ5: Branch literal loads PC plus one plus sign-extended operand.
// RQ6: Return stack holds 16 entries of 15 bits, outside memory spaces.
// RQ7: Calls and interrupts push, returns pop; the high latch stays unchanged.
// RQ8: Push increments pointer then writes; pop reads then decrements pointer.
// RQ9: With fault reset off the stack wraps circularly.
// RQ10: Overflow and underflow flags set on faults whatever the reset option.
// RQ11: With fault reset on, a stack fault resets the device and flags it.
// RQ12: Top-of-stack registers show and write the entry at the pointer.
// RQ13: Empty pointer is 0x1F; top reads zero, or entry 0x0F without reset.
// RQ14: Indirect port accesses go to the location its 16-bit pointer gives.
// RQ15: Pointer at either indirect port reads zero and suppresses the write.
// RQ16: Pointers 0x0000 to 0x1FFF map directly onto banked data addresses.
// RQ17: Pointers 0x2000 to 0x2FEF chain the 80-byte blocks of all banks.
// RQ18: Linear addresses without memory behind them read as zero.
// RQ19: Common memory is not part of the linear region.
// RQ20: Pointer MSB set addresses flash; only the low byte is returned.
// RQ21: Writes through the indirect port to flash are ignored.
// RQ22: Indirect flash reads take one extra instruction cycle.
// RQ23: PC is 15 bits, cleared on reset; upper bits only via the latch.
// RQ24: Linear offset n selects bank n/80 at address 0x20 plus n mod 80.
module pcs_core
   import pcs_pkg::*;
(
   // Clock and reset
   input  wire logic          SYS_CLK_I,
   input  wire logic          RESETN_I,
   // Instruction execution
   input  wire pcs_op_t       OP_I,
   input  wire logic [10:0]   CALL_ADDR_I,
   input  wire logic [8:0]    BRA_OFFSET_I,
   input  wire logic [7:0]    W_I,
   input  wire logic [7:0]    PC_LOW_WDATA_I,
   input  wire logic          PC_ADVANCE_I,
   input  wire logic          STACK_FAULT_RESET_EN_I,
   // Register port
   input  wire logic [1:0]    REG_ADDR_I,
   input  wire logic [7:0]    REG_WDATA_I,
   input  wire logic          REG_WR_I,
   input  wire logic          REG_RD_I,
   output logic [7:0]         REG_RDATA_O,
   input  wire logic [6:0]    PC_HIGH_LATCH_I,
   // Indirect pointer decode
   input  wire logic [15:0]   IND_PTR_I,
   input  wire logic          IND_WRITE_I,
   input  wire logic          IND_READ_I,
   input  wire logic [13:0]   FLASH_WORD_I,
   input  wire logic [7:0]    DATA_RDATA_I,
   output pcs_ind_t           IND_O,
   output logic [7:0]         IND_RDATA_O,
   output logic               IND_STALL_O,
   // State
   output logic [14:0]        PC_O,
   output logic [14:0]        RET_PC_O,
   output logic               STACK_FAULT_RESET_O,
   output logic               STACK_OVERFLOW_FLAG_O,
   output logic               STACK_UNDERFLOW_FLAG_O,
   output logic [4:0]         STACK_POINTER_O
);

   logic [14:0] pc;
   logic [14:0] stack_mem [STACK_DEPTH];                                   // RQ6
   logic [4:0]  stack_pointer_reg;
   logic        stack_overflow_flag;
   logic        stack_underflow_flag;
   logic        fault_reset;
   logic        flash_wait;
   logic [7:0]  rdata;

   wire logic [14:0] pc_inc   = pc + 15'h0001;
   wire logic [14:0] pc_brw   = pc_inc + {7'h00, W_I};                   // RQ4
   wire logic [14:0] pc_bra   = pc_inc + {{6{BRA_OFFSET_I[8]}}, BRA_OFFSET_I}; // RQ5
   wire logic        do_push  = (OP_I == PCS_OP_CALL) || (OP_I == PCS_OP_CALL_VIA_WORKING)
                                || (OP_I == PCS_OP_IRQ);                  // RQ7
   wire logic        do_pop   = (OP_I == PCS_OP_RET);                    // RQ7
   wire logic        sp_empty = (stack_pointer_reg == SP_EMPTY);
   wire logic        sp_full  = (stack_pointer_reg == SP_TOP);
   wire logic [3:0]  sp_idx   = stack_pointer_reg[3:0];
   wire logic [4:0]  sp_inc   = sp_empty ? 5'h00 : stack_pointer_reg + 5'h01;
   wire logic [3:0]  push_idx = sp_full ? 4'h0 : sp_inc[3:0];             // RQ9
   wire logic        overflow = do_push && sp_full;                        // RQ10
   wire logic        underflow = do_pop && sp_empty;                       // RQ10
   wire logic        tos_zero = sp_empty && STACK_FAULT_RESET_EN_I;         // RQ13
   wire logic [14:0] tos      = tos_zero ? PC_RESET : stack_mem[sp_idx];   // RQ12
   wire logic        tos_wr_lo = REG_WR_I && (REG_ADDR_I == REG_TOS_LOW);
   wire logic        tos_wr_hi = REG_WR_I && (REG_ADDR_I == REG_TOS_HIGH);
   wire logic        sp_wr     = REG_WR_I && (REG_ADDR_I == REG_SP);

   logic [14:0] next_pc;
   always_comb begin
      case (OP_I)
         PCS_OP_CALL:   next_pc = {PC_HIGH_LATCH_I[6:3], CALL_ADDR_I};     // RQ2
         PCS_OP_CALL_VIA_WORKING:  next_pc = {PC_HIGH_LATCH_I, W_I};                  // RQ3
         PCS_OP_BRW:    next_pc = pc_brw;
         PCS_OP_BRA:    next_pc = pc_bra;
         PCS_OP_PCL_WR: next_pc = {PC_HIGH_LATCH_I, PC_LOW_WDATA_I};       // RQ1
         PCS_OP_RET:    next_pc = stack_mem[sp_idx];                       // RQ8
         default:       next_pc = PC_ADVANCE_I ? pc_inc : pc;
      endcase
   end

   // RQ23
   always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         pc <= PC_RESET;
      end else if (fault_reset) begin
         pc <= PC_RESET;
      end else begin
         pc <= next_pc;
      end
   end

   // The stack array has no reset; only the pointer defines emptiness.
   always_ff @(posedge SYS_CLK_I) begin
      if (do_push && !(overflow && STACK_FAULT_RESET_EN_I)) begin
         stack_mem[push_idx] <= (OP_I == PCS_OP_IRQ) ? pc : pc_inc;        // RQ8
      end else if (tos_wr_lo) begin
         stack_mem[sp_idx][7:0] <= REG_WDATA_I;                             // RQ12
      end else if (tos_wr_hi) begin
         stack_mem[sp_idx][14:8] <= REG_WDATA_I[6:0];                       // RQ12
      end
   end

   logic [4:0] next_sp;
   always_comb begin
      if (do_push) begin
         next_sp = sp_full ? 5'h00 : sp_inc;                               // RQ9
      end else if (do_pop) begin
         next_sp = (stack_pointer_reg == 5'h00) ? SP_EMPTY
                 : sp_empty ? SP_TOP : stack_pointer_reg - 5'h01;          // RQ8
      end else if (sp_wr) begin
         next_sp = REG_WDATA_I[4:0];                                        // RQ12
      end else begin
         next_sp = stack_pointer_reg;
      end
   end

   // Flags survive the stack fault reset so software can see its cause.
   always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         stack_pointer_reg    <= SP_EMPTY;                                  // RQ13
         stack_overflow_flag  <= 1'b0;
         stack_underflow_flag <= 1'b0;
         fault_reset          <= 1'b0;
      end else begin
         stack_pointer_reg    <= fault_reset ? SP_EMPTY : next_sp;
         stack_overflow_flag  <= overflow
                                 || (stack_overflow_flag && !(REG_WR_I
                                 && REG_ADDR_I == REG_FLAGS && !REG_WDATA_I[1])); // RQ10
         stack_underflow_flag <= underflow
                                 || (stack_underflow_flag && !(REG_WR_I
                                 && REG_ADDR_I == REG_FLAGS && !REG_WDATA_I[0])); // RQ10
         fault_reset          <= (overflow || underflow) && STACK_FAULT_RESET_EN_I; // RQ11
      end
   end

   wire logic [7:0] rd_mux =
      (REG_ADDR_I == REG_TOS_LOW)  ? tos[7:0] :
      (REG_ADDR_I == REG_TOS_HIGH) ? {1'b0, tos[14:8]} :
      (REG_ADDR_I == REG_SP)       ? {3'h0, stack_pointer_reg} :
      {6'h00, stack_overflow_flag, stack_underflow_flag};

   always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         rdata <= 8'h00;
      end else begin
         rdata <= REG_RD_I ? rd_mux : 8'h00;
      end
   end

   // Indirect decode. Linear offset split into bank and in-bank address.
   wire logic        is_flash   = IND_PTR_I[FLASH_BIT];                    // RQ20
   wire logic        is_banked  = !is_flash && (IND_PTR_I <= BANKED_LAST);  // RQ16
   wire logic        is_linear  = !is_flash && (IND_PTR_I >= LINEAR_FIRST)
                                  && (IND_PTR_I <= LINEAR_LAST);            // RQ17
   wire logic [12:0] lin_off    = IND_PTR_I[12:0];
   wire logic [12:0] lin_bank   = lin_off / GPR_BLOCK;                      // RQ24
   wire logic [12:0] lin_mod    = lin_off % GPR_BLOCK;                      // RQ24
   wire logic [15:0] lin_addr   = {lin_bank[8:0], GPR_BASE + lin_mod[6:0]}; // RQ19
   wire logic        is_port    = (IND_PTR_I == PORT0_ADDR)
                                  || (IND_PTR_I == PORT1_ADDR);             // RQ15
   pcs_ind_t next_ind;
   always_comb begin
      next_ind.region    = is_flash ? REGION_FLASH
                         : (is_banked || is_linear) ? REGION_DATA : REGION_NONE; // RQ18
      next_ind.addr      = is_flash ? {1'b0, IND_PTR_I[14:0]}
                         : is_linear ? lin_addr : IND_PTR_I;                // RQ14
      next_ind.suppress  = is_port || is_flash || !(is_banked || is_linear); // RQ21
      next_ind.read_zero = is_port || !(is_flash || is_banked || is_linear);
   end

   wire logic [7:0] ind_data = next_ind.read_zero ? 8'h00
                             : is_flash ? FLASH_WORD_I[7:0] : DATA_RDATA_I; // RQ20

   always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         flash_wait <= 1'b0;
         IND_O      <= '0;
         IND_RDATA_O <= 8'h00;
      end else begin
         flash_wait  <= IND_READ_I && is_flash && !flash_wait;             // RQ22
         IND_O       <= next_ind;
         IND_RDATA_O <= ind_data;
      end
   end

   assign IND_STALL_O            = IND_READ_I && is_flash && !flash_wait;  // RQ22
   assign REG_RDATA_O            = rdata;
   assign PC_O                   = pc;
   assign RET_PC_O               = tos;
   assign STACK_FAULT_RESET_O    = fault_reset;
   assign STACK_OVERFLOW_FLAG_O  = stack_overflow_flag;
   assign STACK_UNDERFLOW_FLAG_O = stack_underflow_flag;
   assign STACK_POINTER_O        = stack_pointer_reg;

   wire unused_ok = IND_WRITE_I;

   pc_write_a: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I) // RQ1
      (OP_I == PCS_OP_PCL_WR) && !fault_reset
      |=> pc == {$past(PC_HIGH_LATCH_I), $past(PC_LOW_WDATA_I)})
      else $error("low byte write did not load whole counter");
   call_load_a: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I) // RQ2
      (OP_I == PCS_OP_CALL) && !fault_reset
      |=> pc == {$past(PC_HIGH_LATCH_I[6:3]), $past(CALL_ADDR_I)})
      else $error("call target wrong");
   brw_load_a: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I) // RQ4
      (OP_I == PCS_OP_BRW) && !fault_reset
      |=> pc == $past(pc) + 15'h0001 + {7'h00, $past(W_I)})
      else $error("branch via working target wrong");
   push_ptr_a: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I) // RQ8
      do_push && !sp_full && !sp_empty && !fault_reset
      |=> stack_pointer_reg == $past(stack_pointer_reg) + 5'h01)
      else $error("push did not advance pointer");
   ovf_flag_a: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I) // RQ10
      overflow |=> stack_overflow_flag)
      else $error("overflow flag not set");
   fault_rst_a: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I) // RQ11
      (overflow || underflow) && STACK_FAULT_RESET_EN_I
      |=> fault_reset ##1 (pc == PC_RESET && stack_pointer_reg == SP_EMPTY))
      else $error("stack fault reset missing");
   port_zero_a: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I) // RQ15
      is_port |=> IND_RDATA_O == 8'h00 && IND_O.suppress)
      else $error("self pointer not blocked");
   flash_wait_a: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I) // RQ22
      IND_READ_I && is_flash && !flash_wait |=> flash_wait)
      else $error("flash read took no extra cycle");
   call_via_working_load_a: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I) // RQ3
      (OP_I == PCS_OP_CALL_VIA_WORKING) && !fault_reset
      |=> pc == {$past(PC_HIGH_LATCH_I), $past(W_I)})
      else $error("call via working target wrong");
   bra_load_a: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I) // RQ5
      (OP_I == PCS_OP_BRA) && !fault_reset
      |=> pc == $past(pc) + 15'h0001
               + {{6{$past(BRA_OFFSET_I[8])}}, $past(BRA_OFFSET_I)})
      else $error("literal branch target wrong");
   ret_load_a: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I) // RQ8
      do_pop && !sp_empty && !fault_reset
      |=> pc == $past(RET_PC_O))
      else $error("return did not load stacked counter");
   pop_ptr_a: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I) // RQ8
      do_pop && !sp_empty && (stack_pointer_reg != 5'h00) && !fault_reset
      |=> stack_pointer_reg == $past(stack_pointer_reg) - 5'h01)
      else $error("pop did not lower pointer");
   push_wrap_a: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I) // RQ9
      do_push && sp_full && !STACK_FAULT_RESET_EN_I && !fault_reset
      |=> stack_pointer_reg == 5'h00)
      else $error("full stack did not wrap");
   unf_flag_a: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I) // RQ10
      underflow |=> stack_underflow_flag)
      else $error("underflow flag not set");
   flash_supp_a: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I) // RQ21
      is_flash |=> IND_O.suppress && (IND_O.region == REGION_FLASH))
      else $error("flash write not suppressed");

endmodule : pcs_core

`default_nettype wire

// ==== dv/pcs_mem_model.sv ====
// Data memory and program flash seen through the indirect pointer.
// Assumes the pointer stays steady while a read strobe is high.
`timescale 1ns/1ns
`default_nettype none
module pcs_mem_model (
   // Pointer side
   input  wire logic [15:0] ptr_i,
   input  wire logic        rd_i,
   // Read data
   output logic      [7:0]  data_o,
   output logic      [13:0] flash_o
);
   logic [7:0]  dval;
   logic [13:0] fval;
   assign dval = ptr_i[7:0] ^ ptr_i[15:8] ^ 8'h5a;
   assign fval = ptr_i[13:0] ^ 14'h2a5a;
   // Outside a read the data are inverted, so a stale value never passes.
   assign data_o  = rd_i ? dval : ~dval;
   assign flash_o = rd_i ? fval : ~fval;
endmodule : pcs_mem_model
`default_nettype wire

// ==== dv/tb_top.sv ====
// Self-checking bench for pcs_core against an integer model of PC and stack.
// Assumes the memory model answers the pointer combinationally.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   import pcs_pkg::*;
   logic        sys_clk = 1'b0, resetn = 1'b0, adv = 1'b0, fen = 1'b0;
   logic        reg_wr = 1'b0, reg_rd = 1'b0, ind_wr = 1'b0, ind_rd = 1'b0;
   pcs_op_t     op = PCS_OP_NONE;
   logic [10:0] call_addr = '0;
   logic [8:0]  bra_off = '0;
   logic [7:0]  w = '0, pcl_d = '0, reg_wd = '0, dat, reg_rdata, ind_rdata;
   logic [1:0]  reg_a = '0;
   logic [6:0]  lat = '0;
   logic [15:0] ptr = '0;
   logic [13:0] fword;
   pcs_ind_t    ind;
   logic        stall, fault, ovf, unf;
   logic [14:0] pc_o, ret_pc;
   logic [4:0]  sp_o;
   int          n_mismatch = 0, samples_checked = 0, seed = 44358;
   int          pc = 0, sp = 31, stk[16];
   bit          known = 1, e_ovf = 0, e_unf = 0, sv[16];
   logic [15:0] plist [10] = '{16'h0000, 16'h0001, 16'h1234, 16'h1fff, 16'h2000,
                               16'h204f, 16'h2050, 16'h2fef, 16'h3000, 16'hffff};

   pcs_core i_pcs_core (.SYS_CLK_I(sys_clk), .RESETN_I(resetn), .OP_I(op),
      .CALL_ADDR_I(call_addr), .BRA_OFFSET_I(bra_off), .W_I(w), .PC_LOW_WDATA_I(pcl_d),
      .PC_ADVANCE_I(adv), .STACK_FAULT_RESET_EN_I(fen), .REG_ADDR_I(reg_a),
      .REG_WDATA_I(reg_wd), .REG_WR_I(reg_wr), .REG_RD_I(reg_rd), .REG_RDATA_O(reg_rdata),
      .PC_HIGH_LATCH_I(lat), .IND_PTR_I(ptr), .IND_WRITE_I(ind_wr), .IND_READ_I(ind_rd),
      .FLASH_WORD_I(fword), .DATA_RDATA_I(dat), .IND_O(ind), .IND_RDATA_O(ind_rdata),
      .IND_STALL_O(stall), .PC_O(pc_o), .RET_PC_O(ret_pc), .STACK_FAULT_RESET_O(fault),
      .STACK_OVERFLOW_FLAG_O(ovf), .STACK_UNDERFLOW_FLAG_O(unf), .STACK_POINTER_O(sp_o));
   pcs_mem_model i_pcs_mem_model (.ptr_i(ptr), .rd_i(ind_rd), .data_o(dat), .flash_o(fword));

   always #5 sys_clk = ~sys_clk;

   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   task automatic results;
      if (n_mismatch == 0 && samples_checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : results

   task automatic chk_state;
      if (known) chk("pc", pc_o, pc);
      chk("sp", sp_o, sp);
      chk("flags", {ovf, unf}, {e_ovf, e_unf});
      if (sp < 16 && sv[sp]) chk("tos", ret_pc, stk[sp]);
   endtask : chk_state

   task automatic push(input int v);
      if (sp == 15) e_ovf = 1;
      sp = (sp == 31 || sp == 15) ? 0 : sp + 1;
      stk[sp] = v;
      sv[sp] = known;
   endtask : push

   task automatic do_op(input pcs_op_t o);
      int nx;
      int ofs;
      @(posedge sys_clk);
      op <= o;
      nx = (pc + 1) % 32768;
      ofs = $signed(bra_off);
      case (o)
         PCS_OP_CALL: begin push(nx); pc = {lat[6:3], call_addr}; known = 1; end
         PCS_OP_CALL_VIA_WORKING: begin push(nx); pc = {lat, w}; known = 1; end
         PCS_OP_IRQ: push(pc);
         PCS_OP_BRW: pc = (nx + w) % 32768;
         PCS_OP_BRA: pc = (nx + ofs) & 'h7fff;
         PCS_OP_PCL_WR: begin pc = {lat, pcl_d}; known = 1; end
         PCS_OP_RET: begin
            if (sp == 31) begin e_unf = 1; sp = 15; known = 0; end
            else begin pc = stk[sp]; known = sv[sp]; sp = (sp == 0) ? 31 : sp - 1; end
         end
         default: ;
      endcase
      @(posedge sys_clk);
      op <= PCS_OP_NONE;
      {call_addr, bra_off, w, pcl_d} <= 36'({$random(seed), $random(seed)});
      lat <= 7'($random(seed));
      #1 chk_state;
   endtask : do_op

   task automatic reg_access(input logic [1:0] a, input bit wr, input int d);
      @(posedge sys_clk);
      reg_a <= a;
      reg_wd <= 8'(d);
      reg_wr <= wr;
      reg_rd <= !wr;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      #1 if (!wr) chk("reg", reg_rdata, d);
   endtask : reg_access

   task automatic do_reset;
      @(posedge sys_clk);
      resetn <= 1'b0;
      repeat (5) @(posedge sys_clk);
      resetn <= 1'b1;
      {pc, sp, known, e_ovf, e_unf} = {32'd0, 32'd31, 3'b100};
      #1 chk_state;
   endtask : do_reset

   task automatic fault_case(input pcs_op_t o);
      int i;
      @(posedge sys_clk);
      op <= o;
      @(posedge sys_clk);
      op <= PCS_OP_NONE;
      #1;
      for (i = 0; i < 4 && fault !== 1'b1; i++) @(posedge sys_clk) #1;
      chk("fault", fault, 1);
      if (fault !== 1'b1) results();
      @(posedge sys_clk) #1 chk("pulse", fault, 0);
      repeat (2) @(posedge sys_clk);
      if (o == PCS_OP_CALL) e_ovf = 1;
      else e_unf = 1;
      {pc, sp, known} = {32'd0, 32'd31, 1'b1};
      #1 chk_state;
   endtask : fault_case

   task automatic ind_acc(input logic [15:0] p, input bit wr);
      pcs_ind_t e;
      int n;
      logic [7:0] d;
      n = p - 16'h2000;
      e = '0;
      d = p[7:0] ^ p[15:8] ^ 8'h5a;
      @(posedge sys_clk);
      ptr <= p;
      ind_rd <= !wr;
      ind_wr <= wr;
      if (p[15] && !wr) begin
         #1 chk("stall", stall, 1);
         @(posedge sys_clk) #1 chk("stall2", stall, 0);
      end
      @(posedge sys_clk);
      ind_rd <= 1'b0;
      ind_wr <= 1'b0;
      if (p[15]) begin e.region = REGION_FLASH; e.addr = p; e.suppress = 1; d = p[7:0] ^ 8'h5a; end
      else if (p <= BANKED_LAST) begin e.addr = p; e.suppress = p <= 1; e.read_zero = p <= 1; end
      else if (p <= LINEAR_LAST) e.addr = (n / 80) * 128 + 32 + n % 80;
      else begin e.region = REGION_NONE; e.suppress = 1; e.read_zero = 1; d = '0; end
      if (p <= 16'h0001) d = '0;
      #1 chk("region", ind.region, e.region);
      if (e.region != REGION_NONE) chk("addr", ind.addr[14:0], e.addr[14:0]);
      chk("supp", {ind.suppress, ind.read_zero}, {e.suppress, e.read_zero});
      if (!wr) chk("rdata", ind_rdata, d);
   endtask : ind_acc

   initial begin
      do_reset();
      do_op(PCS_OP_PCL_WR);
      repeat (80) do_op(pcs_op_t'(3'($random(seed))));
      do_op(PCS_OP_PCL_WR);
      @(posedge sys_clk);
      adv <= 1'b1;
      repeat (3) @(posedge sys_clk);
      adv <= 1'b0;
      pc = (pc + 3) % 32768;
      #1 chk_state;
      reg_access(REG_FLAGS, 1, 0);
      {e_ovf, e_unf} = 2'b00;
      reg_access(REG_FLAGS, 0, 0);
      repeat (17) do_op(PCS_OP_CALL);
      reg_access(REG_FLAGS, 0, 2);
      reg_access(REG_SP, 1, 3);
      sp = 3;
      reg_access(REG_SP, 0, 3);
      reg_access(REG_TOS_LOW, 0, stk[3] % 256);
      reg_access(REG_TOS_HIGH, 0, stk[3] / 256);
      stk[3] = $random(seed) & 'h7fff;
      reg_access(REG_TOS_LOW, 1, stk[3] % 256);
      reg_access(REG_TOS_HIGH, 1, stk[3] / 256);
      repeat (17) do_op(PCS_OP_RET);
      reg_access(REG_FLAGS, 0, 3);
      foreach (plist[k]) begin
         ind_acc(plist[k], 0);
         ind_acc(plist[k], 1);
      end
      repeat (20) ind_acc(16'($random(seed)), 0);
      fen <= 1'b1;
      do_reset();
      reg_access(REG_TOS_LOW, 0, 0);
      reg_access(REG_TOS_HIGH, 0, 0);
      fault_case(PCS_OP_RET);
      reg_access(REG_SP, 1, 15);
      fault_case(PCS_OP_CALL);
      results();
   end
endmodule : tb_top
`default_nettype wire
